/* File: rtl/izs_pkg.sv */
// Shared constants, field layouts and types of the interpolating modulator datapath.
package izs_pkg;

  // Register indices; the byte address of a register is four times its index.
  localparam logic [5:0] CTRL_IDX = 6'h01;
  localparam logic [5:0] STAT_IDX = 6'h02;

  // Control register reset value and writable-bit mask (bit 0 is reserved, reads zero).
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hfe;

  // Interpolation-rate encodings.
  localparam logic [1:0] RATE_1X = 2'h0;
  localparam logic [1:0] RATE_2X = 2'h1;
  localparam logic [1:0] RATE_4X = 2'h2;
  localparam logic [1:0] RATE_8X = 2'h3;

  // Modulation-frequency encodings.
  localparam logic [1:0] MF_OFF = 2'h0;
  localparam logic [1:0] MF_HALF = 2'h1;
  localparam logic [1:0] MF_QUARTER = 2'h2;
  localparam logic [1:0] MF_EIGHTH = 2'h3;

  // Carrier phase offsets that turn the sine sequence into the cosine sequence.
  localparam logic [2:0] QTR_4 = 3'h1;
  localparam logic [2:0] QTR_8 = 3'h2;

  // Carrier coefficients, signed with fourteen fraction bits.
  localparam int COEF_W = 16;
  localparam int COEF_FRAC = 14;
  localparam logic signed [COEF_W-1:0] C_ZERO = 16'sh0000;
  localparam logic signed [COEF_W-1:0] C_ONE = 16'sh4000;
  localparam logic signed [COEF_W-1:0] C_NONE = 16'shc000;
  localparam logic signed [COEF_W-1:0] C_R707 = 16'sh2d41;
  localparam logic signed [COEF_W-1:0] C_NR707 = 16'shd2bf;

  // Status register field positions.
  localparam int ST_PHASE_LSB = 0;
  localparam int ST_REP_LSB = 3;
  localparam int ST_SLOT_BIT = 6;

  // Sample width as documented for the converter path.
  localparam int SAMPLE_W = 16;

  // Control register layout, bit 7 first.
  typedef struct packed {
    logic [1:0] rate;
    logic [1:0] mf;
    logic zero_stuff;
    logic cplx;
    logic pos_exp;
    logic rsvd;
  } izs_ctrl_t;

  // Output slot: a modulated data sample or an inserted midscale sample.
  typedef enum logic {
    SLOT_DATA = 1'b0,
    SLOT_STUFF = 1'b1
  } izs_slot_t;

endpackage

/* File: rtl/izs_mix.sv */
// One carrier multiplier: a sample times a fixed-point coefficient, rescaled.
`timescale 1ns/1ps
module izs_mix #(
  parameter int DW = izs_pkg::SAMPLE_W,
  parameter int CW = izs_pkg::COEF_W,
  parameter int FRAC = izs_pkg::COEF_FRAC
) (
  // Operands
  input wire logic signed [DW-1:0] sample_i,
  input wire logic signed [CW-1:0] coef_i,
  // Product, one bit wider so that a full-scale negative times minus one fits
  output logic signed [DW:0] prod_o
);

  logic signed [DW+CW-1:0] full;

  // The slice below needs room for the sign and the integer bit of the coefficient.
  if (FRAC < 1 || FRAC > CW - 2) begin : g_bad_frac
    $error("izs_mix: fraction width does not fit the coefficient width");
  end

  assign full = sample_i * coef_i;
  assign prod_o = full[FRAC+DW:FRAC];

endmodule

/* File: rtl/izs_top.sv */
// Interpolating modulator with zero stuffing and a classic Wishbone control slave.
`timescale 1ns/1ps
module izs_top #(
  parameter int DW = izs_pkg::SAMPLE_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Baseband sample input, twos complement
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [DW-1:0] in_i_i,
  input wire logic [DW-1:0] in_q_i,
  // Converter samples, offset binary, one per clock
  output logic [DW-1:0] dac_i_o,
  output logic [DW-1:0] dac_q_o
);

  localparam int CW = izs_pkg::COEF_W;
  localparam logic [DW-1:0] MIDSCALE = {1'b1, {(DW-1){1'b0}}};

  typedef struct packed {
    izs_pkg::izs_ctrl_t ctrl;
    logic ack;
    logic [31:0] rdat;
    logic [2:0] phase;
    logic [2:0] rep;
    izs_pkg::izs_slot_t slot;
    logic signed [DW-1:0] hold_i;
    logic signed [DW-1:0] hold_q;
    logic [DW-1:0] dac_i;
    logic [DW-1:0] dac_q;
  } izs_state_t;

  izs_state_t s;
  izs_state_t next_s;

  logic [5:0] idx;
  logic req;
  logic ctrl_wr;
  logic [2:0] rep_max;
  logic rep_last;
  logic in_take;
  logic signed [CW-1:0] car_real;
  logic signed [CW-1:0] car_cos;
  logic signed [CW-1:0] car_sin;
  logic signed [CW-1:0] coef_a;
  logic signed [CW-1:0] coef_b;
  logic signed [DW:0] p_ia;
  logic signed [DW:0] p_qa;
  logic signed [DW:0] p_ib;
  logic signed [DW:0] p_qb;
  logic signed [DW+1:0] sum_re;
  logic signed [DW+1:0] sum_im;

  // Saturation and the offset-binary conversion are only sized for these widths.
  if (DW < 8 || DW > 24) begin : g_bad_width
    $error("izs_top: sample width must lie between 8 and 24 bits");
  end

  // Printed carrier sequence for the selected rate; with modulation off it is unity.
  function automatic logic signed [CW-1:0] seq(input logic [1:0] mf, input logic [2:0] ph);
    logic signed [CW-1:0] c;
    c = izs_pkg::C_ONE;
    case (mf)
      izs_pkg::MF_HALF: begin
        c = ph[0] ? izs_pkg::C_NONE : izs_pkg::C_ONE;
      end
      izs_pkg::MF_QUARTER: begin
        case (ph[1:0])
          2'h1: c = izs_pkg::C_ONE;
          2'h3: c = izs_pkg::C_NONE;
          default: c = izs_pkg::C_ZERO;
        endcase
      end
      izs_pkg::MF_EIGHTH: begin
        case (ph)
          3'h1: c = izs_pkg::C_R707;
          3'h2: c = izs_pkg::C_ONE;
          3'h3: c = izs_pkg::C_R707;
          3'h5: c = izs_pkg::C_NR707;
          3'h6: c = izs_pkg::C_NONE;
          3'h7: c = izs_pkg::C_NR707;
          default: c = izs_pkg::C_ZERO;
        endcase
      end
      default: c = izs_pkg::C_ONE;
    endcase
    return c;
  endfunction

  function automatic logic signed [DW-1:0] sat(input logic signed [DW+1:0] x);
    logic signed [DW-1:0] r;
    r = x[DW-1:0];
    if (x[DW+1:DW-1] != {3{x[DW+1]}}) begin
      r = x[DW+1] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
    end
    return r;
  endfunction

  function automatic logic [DW-1:0] ofs(input logic signed [DW-1:0] x);
    return {~x[DW-1], x[DW-2:0]};
  endfunction

  // Bus decode; a write lands on the edge at which the master sees ack.
  assign idx = adr_i[7:2];
  assign req = cyc_i && stb_i;
  assign ctrl_wr = req && we_i && s.ack && sel_i[0] && (idx == izs_pkg::CTRL_IDX);

  // Interpolation by sample repetition: each input is held for 1, 2, 4 or 8 data slots.
  always_comb begin
    case (s.ctrl.rate)
      izs_pkg::RATE_2X: rep_max = 3'h1;
      izs_pkg::RATE_4X: rep_max = 3'h3;
      izs_pkg::RATE_8X: rep_max = 3'h7;
      default: rep_max = 3'h0;
    endcase
  end

  // Greater-or-equal keeps the counter safe when software lowers the rate mid-run.
  assign rep_last = s.rep >= rep_max;
  assign in_ready_o = (s.slot == izs_pkg::SLOT_DATA) && rep_last;
  assign in_take = in_ready_o && in_valid_i;

  // Carrier generation from the phase counter and the frequency field.
  always_comb begin
    car_real = seq(s.ctrl.mf, s.phase);
    car_cos = car_real;
    car_sin = izs_pkg::C_ZERO;
    case (s.ctrl.mf)
      // No quadrature pair exists at half rate, so the sine term is zero there.
      izs_pkg::MF_QUARTER: begin
        car_sin = car_real;
        car_cos = seq(s.ctrl.mf, 3'(s.phase + izs_pkg::QTR_4));
      end
      izs_pkg::MF_EIGHTH: begin
        car_sin = car_real;
        car_cos = seq(s.ctrl.mf, 3'(s.phase + izs_pkg::QTR_8));
      end
      default: begin
        car_sin = izs_pkg::C_ZERO;
      end
    endcase
    if (s.ctrl.cplx) begin
      coef_a = car_cos;
      coef_b = s.ctrl.pos_exp ? car_sin : CW'(-car_sin);
    end else begin
      coef_a = car_real;
      coef_b = izs_pkg::C_ZERO;
    end
  end

  izs_mix #(.DW(DW)) u_mix_ia (.sample_i(s.hold_i), .coef_i(coef_a), .prod_o(p_ia));
  izs_mix #(.DW(DW)) u_mix_qa (.sample_i(s.hold_q), .coef_i(coef_a), .prod_o(p_qa));
  izs_mix #(.DW(DW)) u_mix_ib (.sample_i(s.hold_i), .coef_i(coef_b), .prod_o(p_ib));
  izs_mix #(.DW(DW)) u_mix_qb (.sample_i(s.hold_q), .coef_i(coef_b), .prod_o(p_qb));

  // In real mode the b products are zero, so one adder pair serves both modes.
  assign sum_re = {p_ia[DW], p_ia} - {p_qb[DW], p_qb};
  assign sum_im = {p_ib[DW], p_ib} + {p_qa[DW], p_qa};

  always_comb begin
    next_s = s;
    next_s.ack = req && !s.ack;
    next_s.rdat = 32'h0000_0000;
    if (idx == izs_pkg::CTRL_IDX) begin
      next_s.rdat[7:0] = s.ctrl;
    end else if (idx == izs_pkg::STAT_IDX) begin
      next_s.rdat[izs_pkg::ST_PHASE_LSB +: 3] = s.phase;
      next_s.rdat[izs_pkg::ST_REP_LSB +: 3] = s.rep;
      next_s.rdat[izs_pkg::ST_SLOT_BIT] = s.slot;
    end
    if (ctrl_wr) begin
      next_s.ctrl = dat_i[7:0] & izs_pkg::CTRL_WMASK;
    end
    case (s.slot)
      izs_pkg::SLOT_DATA: begin
        next_s.dac_i = ofs(sat(sum_re));
        next_s.dac_q = ofs(sat(sum_im));
        next_s.phase = 3'(s.phase + 3'h1);
        next_s.rep = rep_last ? 3'h0 : 3'(s.rep + 3'h1);
        if (in_take) begin
          next_s.hold_i = in_i_i;
          next_s.hold_q = in_q_i;
        end
        next_s.slot = s.ctrl.zero_stuff ? izs_pkg::SLOT_STUFF : izs_pkg::SLOT_DATA;
      end
      izs_pkg::SLOT_STUFF: begin
        // Phase and repeat count hold still: stuffing sits after the modulator.
        next_s.dac_i = MIDSCALE;
        next_s.dac_q = MIDSCALE;
        next_s.slot = izs_pkg::SLOT_DATA;
      end
      default: begin
        next_s.slot = izs_pkg::SLOT_DATA;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.ctrl <= izs_pkg::CTRL_RESET;
      s.ack <= 1'b0;
      s.rdat <= 32'h0000_0000;
      s.phase <= 3'h0;
      s.rep <= 3'h0;
      s.slot <= izs_pkg::SLOT_DATA;
      s.hold_i <= '0;
      s.hold_q <= '0;
      s.dac_i <= MIDSCALE;
      s.dac_q <= MIDSCALE;
    end else begin
      s <= next_s;
    end
  end

  assign dat_o = s.rdat;
  assign ack_o = s.ack;
  assign dac_i_o = s.dac_i;
  assign dac_q_o = s.dac_q;

  property p_rate8;
    @(posedge clk_i) disable iff (rst_i || ctrl_wr)
    (in_take && s.ctrl.rate == izs_pkg::RATE_8X && !s.ctrl.zero_stuff)
      |=> (!in_ready_o) [*7] ##1 in_ready_o;
  endproperty
  a_rate8: assert property (p_rate8) else $error("eight-times rate spacing wrong");

  property p_seq8;
    @(posedge clk_i) disable iff (rst_i)
    (!s.ctrl.cplx && s.ctrl.mf == izs_pkg::MF_EIGHTH)
      |-> (s.phase == 3'h7 ? coef_a == izs_pkg::C_NR707 :
           s.phase == 3'h6 ? coef_a == izs_pkg::C_NONE : 1'b1);
  endproperty
  a_seq8: assert property (p_seq8) else $error("eighth-rate carrier entry wrong");

  property p_nostuff;
    @(posedge clk_i) disable iff (rst_i || ctrl_wr)
    (!s.ctrl.zero_stuff && s.slot == izs_pkg::SLOT_DATA) |=> s.slot == izs_pkg::SLOT_DATA;
  endproperty
  a_nostuff: assert property (p_nostuff) else $error("stuff slot while stuffing is off");

  property p_midscale;
    @(posedge clk_i) disable iff (rst_i)
    (s.ctrl.zero_stuff && s.slot == izs_pkg::SLOT_DATA)
      |=> s.slot == izs_pkg::SLOT_STUFF ##1 (dac_i_o == MIDSCALE && dac_q_o == MIDSCALE);
  endproperty
  a_midscale: assert property (p_midscale) else $error("midscale sample not inserted");

  property p_phase_hold;
    @(posedge clk_i) disable iff (rst_i)
    (s.slot == izs_pkg::SLOT_STUFF) |=> (s.phase == $past(s.phase) && !$past(in_ready_o));
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase moved in a stuff slot");

  property p_cplx_re;
    @(posedge clk_i) disable iff (rst_i)
    (s.ctrl.cplx && s.ctrl.mf == izs_pkg::MF_QUARTER && s.phase[1:0] == 2'h0 &&
     s.slot == izs_pkg::SLOT_DATA) |=> (dac_i_o == ofs($past(s.hold_i)) &&
     dac_q_o == ofs($past(s.hold_q)));
  endproperty
  a_cplx_re: assert property (p_cplx_re) else $error("complex product wrong at phase 0");

  property p_cplx_im;
    @(posedge clk_i) disable iff (rst_i)
    (s.ctrl.cplx && s.ctrl.pos_exp && s.ctrl.mf == izs_pkg::MF_QUARTER &&
     s.phase[1:0] == 2'h1 && s.slot == izs_pkg::SLOT_DATA)
      |=> dac_q_o == ofs($past(s.hold_i));
  endproperty
  a_cplx_im: assert property (p_cplx_im) else $error("complex sine coupling wrong");

  property p_sign;
    @(posedge clk_i) disable iff (rst_i)
    (s.ctrl.cplx && !s.ctrl.pos_exp && s.ctrl.mf == izs_pkg::MF_QUARTER &&
     s.phase[1:0] == 2'h1 && s.slot == izs_pkg::SLOT_DATA)
      |=> dac_i_o == ofs($past(s.hold_q));
  endproperty
  a_sign: assert property (p_sign) else $error("negative exponent not applied");

  property p_bypass;
    @(posedge clk_i) disable iff (rst_i || ctrl_wr)
    (s.ctrl.rate == izs_pkg::RATE_1X && !s.ctrl.zero_stuff) |=> in_ready_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass does not take every cycle");

  property p_half;
    @(posedge clk_i) disable iff (rst_i)
    (!s.ctrl.cplx && s.ctrl.mf == izs_pkg::MF_HALF)
      |-> coef_a == (s.phase[0] ? izs_pkg::C_NONE : izs_pkg::C_ONE);
  endproperty
  a_half: assert property (p_half) else $error("half-rate carrier wrong");

  property p_rate4;
    @(posedge clk_i) disable iff (rst_i || ctrl_wr)
    (in_take && s.ctrl.rate == izs_pkg::RATE_4X && !s.ctrl.zero_stuff)
      |=> (!in_ready_o) [*3] ##1 in_ready_o;
  endproperty
  a_rate4: assert property (p_rate4) else $error("four-times rate spacing wrong");

  property p_off;
    @(posedge clk_i) disable iff (rst_i)
    (s.ctrl.mf == izs_pkg::MF_OFF) |-> (coef_a == izs_pkg::C_ONE && coef_b == izs_pkg::C_ZERO);
  endproperty
  a_off: assert property (p_off) else $error("modulation not disabled");

endmodule

/* File: verification/izs_src_model.sv */
// Baseband sample source that feeds I and Q pairs to the modulator datapath.
`timescale 1ns/1ps
module izs_src_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control from the bench
  input wire logic stall_i,
  input wire logic [15:0] want_i_i,
  input wire logic [15:0] want_q_i,
  // Sample handshake
  input wire logic ready_i,
  output logic valid_o,
  output logic [15:0] i_o,
  output logic [15:0] q_o
);
  int seed = 7573;
  logic nv;

  // A pair is held until it is taken; an idle bus shows the inverse so it can never pass.
  always @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      i_o <= 16'h0000;
      q_o <= 16'h0000;
    end else if (!valid_o || ready_i) begin
      nv = stall_i ? 1'($random(seed)) : 1'b1;
      valid_o <= nv;
      i_o <= nv ? want_i_i : ~want_i_i;
      q_o <= nv ? want_q_i : ~want_q_i;
    end
  end
endmodule

/* File: verification/test_interp_modulator_zero_stuff.sv */
// Self-checking bench for the interpolating modulator with zero stuffing.
`timescale 1ns/1ps
module test_interp_modulator_zero_stuff;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic ack_o, in_valid_i, in_ready_o;
  logic stall = 1'b0;
  logic [15:0] in_i_i, in_q_i, dac_i_o, dac_q_o;
  logic [15:0] want_i = 16'h0000;
  logic [15:0] want_q = 16'h0000;
  logic [15:0] cap_i [32];
  logic [15:0] cap_q [32];
  int seed = 7573;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;

  izs_top #(.DW(16)) izs_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .in_i_i(in_i_i), .in_q_i(in_q_i),
    .dac_i_o(dac_i_o), .dac_q_o(dac_q_o));

  izs_src_model izs_src_model_inst (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
    .want_i_i(want_i), .want_q_i(want_q), .ready_i(in_ready_o), .valid_o(in_valid_i),
    .i_o(in_i_i), .q_o(in_q_i));

  always #12.5 clk_i = ~clk_i;

  task test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      test_done();
    end
  end

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    // Only the cycle ceiling ends a wait for an answer that never comes.
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  // Sine coefficient of the carrier at a phase, scaled like the design's coefficients.
  function automatic int cf(input logic [1:0] mf, input int p);
    int one = izs_pkg::C_ONE;
    int r = izs_pkg::C_R707;
    int t8 [8] = '{0, r, one, r, 0, -r, -one, -r};
    if (mf == izs_pkg::MF_HALF) return (p % 2) ? -one : one;
    if (mf == izs_pkg::MF_QUARTER) return (p % 4 == 1) ? one : (p % 4 == 3) ? -one : 0;
    return t8[p % 8];
  endfunction

  function automatic logic [15:0] sat(input int v);
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0] ^ 16'h8000;
  endfunction

  function automatic logic [31:0] pred(input logic [7:0] c, input logic signed [15:0] i,
      input logic signed [15:0] q, input int p);
    int s, co;
    if (c[5:4] == izs_pkg::MF_OFF) return {sat(i), sat(q)};
    s = cf(c[5:4], p);
    if (!c[2]) return {sat((i * s) >>> 14), sat((q * s) >>> 14)};
    co = cf(c[5:4], p + ((c[5:4] == izs_pkg::MF_EIGHTH) ? 2 : 1));
    if (c[5:4] == izs_pkg::MF_HALF) begin
      co = s;
      s = 0;
    end
    if (!c[1]) s = -s;
    return {sat((i * co - q * s) >>> 14), sat((i * s + q * co) >>> 14)};
  endfunction

  // The carrier phase is free running, so the stream is matched at every phase and stuff slot.
  task run_cfg(input int ci);
    logic [7:0] c;
    logic [15:0] vi, vq;
    logic [31:0] e;
    logic found, ok;
    int per, last, p;
    c = 8'(ci << 1);
    vi = 16'($random(seed));
    vq = 16'($random(seed));
    if (ci < 16) begin
      vi = 16'h8000;
      vq = 16'h7fff;
    end
    if (c[5:4] == izs_pkg::MF_EIGHTH) begin
      vi &= 16'hc000;
      vq &= 16'hc000;
    end
    stall <= 1'b0;
    want_i <= vi;
    want_q <= vq;
    wb(1'b1, 8'h04, 4'hf, {24'h0, c});
    wb(1'b0, 8'h04, 4'hf, 32'h0);
    check("ctrl", {24'h0, c & izs_pkg::CTRL_WMASK}, rd);
    repeat (40) @(negedge clk_i);
    stall <= 1'($random(seed));
    per = (1 << c[7:6]) * (1 + c[3]);
    last = -1;
    for (int k = 0; k < 32; k++) begin
      @(negedge clk_i);
      cap_i[k] = dac_i_o;
      cap_q[k] = dac_q_o;
      if (in_ready_o === 1'b1) begin
        if (last >= 0) check("ready spacing", per, k - last);
        last = k;
      end
    end
    found = 1'b0;
    for (int off = 0; off < 8; off++) begin
      for (int s = 0; s < 2; s++) begin
        ok = 1'b1;
        p = off;
        for (int k = 0; k < 32; k++) begin
          if (c[3] && ((k + s) % 2 == 1)) begin
            e = 32'h80008000;
          end else begin
            e = pred(c, vi, vq, p);
            p++;
          end
          if (e !== {cap_i[k], cap_q[k]}) ok = 1'b0;
        end
        if (ok) found = 1'b1;
      end
    end
    check("dac stream", 32'h1, {31'h0, found});
    // Without stuffing no slot is ever a stuff slot, and at the bypass rate nothing repeats.
    if (!c[3]) begin
      wb(1'b0, 8'h08, 4'hf, 32'h0);
      check("status", 32'h0, rd & ((c[7:6] == izs_pkg::RATE_1X) ? 32'hffff_fff8 : 32'hffff_ffc0));
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check("reset dac", 32'h80008000, {dac_i_o, dac_q_o});
    wb(1'b0, 8'h04, 4'hf, 32'h0);
    check("ctrl reset", {24'h0, izs_pkg::CTRL_RESET}, rd);
    wb(1'b1, 8'h04, 4'he, 32'hff);
    wb(1'b0, 8'h04, 4'hf, 32'h0);
    check("ctrl unselected", 32'h0, rd);
    wb(1'b1, 8'h0c, 4'hf, 32'hff);
    wb(1'b0, 8'h0c, 4'hf, 32'h0);
    check("unmapped", 32'h0, rd);
    for (int ci = 0; ci < 128; ci++) begin
      run_cfg(ci);
    end
    test_done();
  end
endmodule
